/* File: logic/slpc_pkg.sv */
// Shared constants, encodings and carriers of the segment load protection checker
package slpc_pkg;

    // Register byte offsets on the Wishbone port
    localparam logic [7:0] ADR_CTRL   = 8'h00;
    localparam logic [7:0] ADR_STATUS = 8'h04;
    localparam logic [7:0] ADR_ERR    = 8'h08;
    localparam logic [7:0] ADR_SEL_CS = 8'h0c;
    localparam logic [7:0] ADR_SEL_DE = 8'h10;

    // Control fields and reset values
    localparam int          CTRL_CHECK_EN = 0;
    localparam logic [31:0] CTRL_RST      = 32'h0000_0001;

    // Access byte field positions
    localparam int ACC_PRESENT  = 7;
    localparam int ACC_DPL_HI   = 6;
    localparam int ACC_DPL_LO   = 5;
    localparam int ACC_SEGMENT  = 4;
    localparam int ACC_EXEC     = 3;
    localparam int ACC_ED       = 2;  // Expand-down on data, conforming on code
    localparam int ACC_RW       = 1;  // Writable on data, readable on code
    localparam int ACC_ACCESSED = 0;

    // Selector fields
    localparam int SEL_RPL_HI = 1;
    localparam int SEL_IDX_LO = 2;

    // Offset range and fixed error code
    localparam logic [15:0] OFS_MIN  = 16'h0000;
    localparam logic [15:0] OFS_MAX  = 16'hffff;
    localparam logic [15:0] ERR_ZERO = 16'h0000;

    // Shadow register contents after reset
    localparam logic [15:0] SEL_RST     = 16'h0000;
    localparam logic [7:0]  ACC_CS_RST  = 8'h9b;
    localparam logic [7:0]  ACC_DAT_RST = 8'h93;
    localparam logic [15:0] LIM_RST     = 16'hffff;

    typedef enum logic [1:0] {
        SEG_ES = 2'b00,
        SEG_CS = 2'b01,
        SEG_SS = 2'b10,
        SEG_DS = 2'b11
    } slpc_seg_t;

    typedef enum logic [1:0] {
        KIND_LOAD   = 2'b00,
        KIND_XFER   = 2'b01,
        KIND_RET    = 2'b10,
        KIND_ACCESS = 2'b11
    } slpc_kind_t;

    typedef enum logic [1:0] {
        ACC_READ     = 2'b00,
        ACC_WRITE    = 2'b01,
        ACC_FETCH    = 2'b10,
        ACC_PREFETCH = 2'b11
    } slpc_atype_t;

    typedef struct packed {
        slpc_kind_t  kind;
        slpc_seg_t   seg;
        logic [15:0] sel;
        logic [7:0]  acc;
        logic [15:0] limit;
        logic [15:0] offset;
        slpc_atype_t atype;
    } slpc_req_t;

    typedef struct packed {
        logic        fault;
        logic [15:0] err;
    } slpc_resp_t;

endpackage

/* File: logic/slpc_checker.sv */
// Segment load protection checker with Wishbone control and status registers
`timescale 1ns/1ps

// Overview of operation
// - Current level is the low two bits of the code selector.
// - Current level changes only on a transfer into a code segment.
// - Data selector load needs descriptor level numerically at or above current level.
// - Direct jump or call needs equal descriptor and current level.
// - Every successful descriptor load writes the accessed bit to one.
// - Data and extra loads check type and access; faults name selector.
// - Stack load needs descriptor level equal to current level.
// - Every access offset except prefetch checked against limit; violation faults with code zero.
// - Legal segment types enforced per segment register.
// - Normal segment accepts offsets from zero through the limit.
// - Expand-down segment accepts limit plus one through top offset.
// - Stack takes normal or expand-down data; data and extra take expand-down segments.
// - Checks finish before any memory cycle or register update.
// - Reading execute-only code faults with code zero.
// - Executable segment usable through data or extra only if readable.
// - Code never writable nor loadable into stack; writes fault code zero.
// - Code limit faults on execution and on reads, never on prefetch.
// - Readable non-conforming code loads use the data privilege test.
// - Return may go to same or less privileged code only.
// - Conforming code allows target level numerically below current level.
// - Descriptor level is bits five and six of access byte.
// - Requested level must not exceed descriptor level numerically.
// - Null selector loads into data or extra; use of it faults.
// - Zero access byte is empty; loading it faults naming selector.
module slpc_checker (
    input  wire logic                clk_i,
    input  wire logic                rst_i,
    input  wire logic [7:0]          adr_i,
    input  wire logic [31:0]         dat_i,
    output logic      [31:0]         dat_o,
    input  wire logic                we_i,
    input  wire logic [3:0]          sel_i,
    input  wire logic                cyc_i,
    input  wire logic                stb_i,
    output logic                     ack_o,
    input  wire logic                req_valid_i,
    input  wire slpc_pkg::slpc_req_t req_i,
    output logic                     resp_valid_o,
    output slpc_pkg::slpc_resp_t     resp_o,
    output logic                     acc_wr_o,
    output logic      [15:0]         acc_sel_o,
    output logic      [7:0]          acc_byte_o,
    output logic      [1:0]          current_priv_level_o
);

    // Shadow segment registers, indexed by segment code
    logic [15:0] sreg_sel [4];
    logic [7:0]  sreg_acc [4];
    logic [15:0] sreg_lim [4];
    logic [31:0] ctrl;
    logic [15:0] fault_cnt;
    logic [15:0] last_err;
    logic        last_fault;

    logic        check_en;
    logic [1:0]  current_priv_level;
    logic [1:0]  descriptor_priv_level;
    logic [1:0]  requested_priv_level;
    logic        is_code;
    logic        rw_bit;
    logic        conforming;
    logic        sel_null;
    logic [15:0] sel_err;
    logic [7:0]  cur_acc;
    logic [15:0] cur_lim;
    logic        cur_null;
    logic        in_range;
    logic        next_fault;
    logic [15:0] next_err;
    logic        next_commit;
    logic        next_acc_wr;
    logic [15:0] next_sel;

    assign check_en = ctrl[slpc_pkg::CTRL_CHECK_EN];
    assign current_priv_level      = sreg_sel[slpc_pkg::SEG_CS][slpc_pkg::SEL_RPL_HI:0];
    assign descriptor_priv_level      = req_i.acc[slpc_pkg::ACC_DPL_HI:slpc_pkg::ACC_DPL_LO];
    assign requested_priv_level      = req_i.sel[slpc_pkg::SEL_RPL_HI:0];
    assign is_code  = req_i.acc[slpc_pkg::ACC_EXEC];
    assign rw_bit   = req_i.acc[slpc_pkg::ACC_RW];
    assign conforming = is_code & req_i.acc[slpc_pkg::ACC_ED];
    assign sel_null = (req_i.sel[15:slpc_pkg::SEL_IDX_LO] == 14'h0000);
    assign sel_err  = {req_i.sel[15:slpc_pkg::SEL_IDX_LO], 2'b00};
    assign cur_acc  = sreg_acc[req_i.seg];
    assign cur_lim  = sreg_lim[req_i.seg];
    assign cur_null = (sreg_sel[req_i.seg][15:slpc_pkg::SEL_IDX_LO] == 14'h0000)
                      && (req_i.seg == slpc_pkg::SEG_DS || req_i.seg == slpc_pkg::SEG_ES);

    // Limit window; expand-down only exists on data segments
    always_comb begin
        if (!cur_acc[slpc_pkg::ACC_EXEC] && cur_acc[slpc_pkg::ACC_ED]) begin
            in_range = (req_i.offset > cur_lim) && (req_i.offset <= slpc_pkg::OFS_MAX);
        end else begin
            in_range = (req_i.offset >= slpc_pkg::OFS_MIN) && (req_i.offset <= cur_lim);
        end
    end

    // Verdict of one request, decided fully before any state moves
    always_comb begin
        next_fault  = 1'b0;
        next_err    = slpc_pkg::ERR_ZERO;
        next_commit = 1'b0;
        next_acc_wr = 1'b0;
        next_sel    = req_i.sel;
        unique case (req_i.kind)
            slpc_pkg::KIND_LOAD: begin
                next_commit = 1'b1;
                next_acc_wr = 1'b1;
                if (sel_null && (req_i.seg == slpc_pkg::SEG_DS
                                 || req_i.seg == slpc_pkg::SEG_ES)) begin
                    next_acc_wr = 1'b0;
                end else if (req_i.acc == 8'h00) begin
                    next_fault = 1'b1;
                end else if (!req_i.acc[slpc_pkg::ACC_PRESENT]
                             || !req_i.acc[slpc_pkg::ACC_SEGMENT]) begin
                    next_fault = 1'b1;
                end else begin
                    unique case (req_i.seg)
                        slpc_pkg::SEG_ES, slpc_pkg::SEG_DS: begin
                            // Expand-down data is accepted here
                            if (is_code && !rw_bit) begin
                                next_fault = 1'b1;
                            end else if (!conforming && (descriptor_priv_level < current_priv_level || descriptor_priv_level < requested_priv_level)) begin
                                next_fault = 1'b1;
                            end
                        end
                        slpc_pkg::SEG_SS: begin
                            // Expand-down flag is irrelevant for the stack
                            if (is_code || !rw_bit) begin
                                next_fault = 1'b1;
                            end else if (descriptor_priv_level != current_priv_level || requested_priv_level > descriptor_priv_level) begin
                                next_fault = 1'b1;
                            end
                        end
                        slpc_pkg::SEG_CS: begin
                            next_fault = 1'b1;
                        end
                    endcase
                end
                if (next_fault) begin
                    next_err = sel_err;
                end
            end
            slpc_pkg::KIND_XFER, slpc_pkg::KIND_RET: begin
                next_commit = 1'b1;
                next_acc_wr = 1'b1;
                if (req_i.kind == slpc_pkg::KIND_XFER) begin
                    next_sel = {req_i.sel[15:slpc_pkg::SEL_IDX_LO], current_priv_level};
                end
                if (!req_i.acc[slpc_pkg::ACC_PRESENT] || !req_i.acc[slpc_pkg::ACC_SEGMENT]
                    || !is_code) begin
                    next_fault = 1'b1;
                end else if (req_i.kind == slpc_pkg::KIND_XFER) begin
                    // A more privileged target needs a gate, handled elsewhere
                    next_fault = conforming ? (descriptor_priv_level > current_priv_level) : (descriptor_priv_level != current_priv_level);
                end else begin
                    // New level comes from the return selector
                    next_fault = (requested_priv_level < current_priv_level) || (conforming ? (descriptor_priv_level > requested_priv_level) : (descriptor_priv_level != requested_priv_level));
                end
                if (next_fault) begin
                    next_err = sel_err;
                end
            end
            slpc_pkg::KIND_ACCESS: begin
                if (req_i.atype == slpc_pkg::ACC_PREFETCH) begin
                    next_fault = 1'b0;
                end else if (cur_null) begin
                    next_fault = 1'b1;
                end else if (req_i.atype == slpc_pkg::ACC_READ && cur_acc[slpc_pkg::ACC_EXEC]
                             && !cur_acc[slpc_pkg::ACC_RW]) begin
                    next_fault = 1'b1;
                end else if (req_i.atype == slpc_pkg::ACC_WRITE && (cur_acc[slpc_pkg::ACC_EXEC]
                             || !cur_acc[slpc_pkg::ACC_RW])) begin
                    next_fault = 1'b1;
                end else if (req_i.atype == slpc_pkg::ACC_FETCH
                             && !cur_acc[slpc_pkg::ACC_EXEC]) begin
                    next_fault = 1'b1;
                end else begin
                    next_fault = !in_range;
                end
                next_err = slpc_pkg::ERR_ZERO;
            end
        endcase
        // Checking disabled: every request passes unchanged
        if (!check_en) begin
            next_fault = 1'b0;
            next_err   = slpc_pkg::ERR_ZERO;
        end
    end

    // Shadow register update only on a clean load, transfer or return, one per entry
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_sreg
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    sreg_sel[g] <= slpc_pkg::SEL_RST;
                    sreg_acc[g] <= (g == 1) ? slpc_pkg::ACC_CS_RST : slpc_pkg::ACC_DAT_RST;
                    sreg_lim[g] <= slpc_pkg::LIM_RST;
                end else if (req_valid_i && next_commit && !next_fault) begin
                    if ((req_i.kind == slpc_pkg::KIND_LOAD && req_i.seg == 2'(g))
                        || (req_i.kind != slpc_pkg::KIND_LOAD && g == 1)) begin
                        sreg_sel[g] <= next_sel;
                        sreg_acc[g] <= req_i.acc | 8'h01;
                        sreg_lim[g] <= req_i.limit;
                    end
                end
            end
        end
    endgenerate

    // Response to the execution logic, one cycle after the request
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            resp_valid_o <= 1'b0;
            resp_o       <= '0;
        end else begin
            resp_valid_o <= req_valid_i;
            resp_o.fault <= req_valid_i & next_fault;
            resp_o.err   <= req_valid_i ? next_err : slpc_pkg::ERR_ZERO;
        end
    end

    // Accessed-bit write back into the descriptor table
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            acc_wr_o   <= 1'b0;
            acc_sel_o  <= slpc_pkg::SEL_RST;
            acc_byte_o <= 8'h00;
        end else begin
            acc_wr_o   <= req_valid_i && next_acc_wr && !next_fault;
            acc_sel_o  <= req_i.sel;
            acc_byte_o <= req_i.acc | 8'h01;
        end
    end

    // Current level output follows the code shadow on transfers and returns, with no extra lag
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            current_priv_level_o <= slpc_pkg::SEL_RST[1:0];
        end else if (req_valid_i && req_i.kind != slpc_pkg::KIND_LOAD
                     && req_i.kind != slpc_pkg::KIND_ACCESS && !next_fault) begin
            current_priv_level_o <= next_sel[1:0];
        end
    end

    // Fault statistics for software
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fault_cnt  <= 16'h0000;
            last_err   <= slpc_pkg::ERR_ZERO;
            last_fault <= 1'b0;
        end else if (req_valid_i) begin
            last_fault <= next_fault;
            if (next_fault) begin
                fault_cnt <= fault_cnt + 16'h0001;  // Wraps; software takes deltas
                last_err  <= next_err;
            end
        end
    end

    // Wishbone classic slave: ack one cycle after strobe, dropped the next
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h0000_0000;
            ctrl  <= slpc_pkg::CTRL_RST;
        end else begin
            ack_o <= cyc_i && stb_i && !ack_o;
            if (cyc_i && stb_i && !ack_o && we_i && adr_i == slpc_pkg::ADR_CTRL
                && sel_i[0]) begin
                ctrl <= {31'h0000_0000, dat_i[slpc_pkg::CTRL_CHECK_EN]};
            end
            unique case (adr_i)
                slpc_pkg::ADR_CTRL:   dat_o <= ctrl;
                slpc_pkg::ADR_STATUS: dat_o <= {fault_cnt, 13'h0000, last_fault, current_priv_level};
                slpc_pkg::ADR_ERR:    dat_o <= {16'h0000, last_err};
                slpc_pkg::ADR_SEL_CS: dat_o <= {sreg_sel[slpc_pkg::SEG_SS],
                                                sreg_sel[slpc_pkg::SEG_CS]};
                slpc_pkg::ADR_SEL_DE: dat_o <= {sreg_sel[slpc_pkg::SEG_DS],
                                                sreg_sel[slpc_pkg::SEG_ES]};
                default:              dat_o <= 32'h0000_0000;  // Unmapped reads zero
            endcase
        end
    end

    // Checks on the protection behaviour
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_load_data;
        req_valid_i && check_en && req_i.kind == slpc_pkg::KIND_LOAD
        && (req_i.seg == slpc_pkg::SEG_DS || req_i.seg == slpc_pkg::SEG_ES);
    endsequence

    sequence s_load_stack;
        req_valid_i && check_en && req_i.kind == slpc_pkg::KIND_LOAD
        && req_i.seg == slpc_pkg::SEG_SS && req_i.acc != 8'h00;
    endsequence

    sequence s_fault_resp;
        resp_valid_o && resp_o.fault;
    endsequence

    a_cpl_only_xfer: assert property ($changed(current_priv_level_o) |->
        $past(req_valid_i && req_i.kind inside {slpc_pkg::KIND_XFER, slpc_pkg::KIND_RET}))
        else $error("level changed without a code transfer");

    a_data_priv_low: assert property (s_load_data ##0 (!sel_null && req_i.acc != 8'h00
        && !conforming && descriptor_priv_level < current_priv_level) |=> s_fault_resp)
        else $error("data load above current level accepted");

    a_jump_same_level: assert property (req_valid_i && check_en
        && req_i.kind == slpc_pkg::KIND_XFER && is_code && !conforming && descriptor_priv_level != current_priv_level
        |=> s_fault_resp ##0 $stable(current_priv_level_o))
        else $error("direct transfer to another level accepted");

    a_accessed_bit: assert property (acc_wr_o |->
        acc_byte_o[slpc_pkg::ACC_ACCESSED] && resp_valid_o && !resp_o.fault)
        else $error("accessed write bad or with fault");

    a_stack_priv: assert property (s_load_stack ##0 (descriptor_priv_level != current_priv_level) |=> s_fault_resp)
        else $error("stack load at other level accepted");

    a_access_err_zero: assert property (req_valid_i
        && req_i.kind == slpc_pkg::KIND_ACCESS |=> resp_o.err == slpc_pkg::ERR_ZERO)
        else $error("access fault with nonzero code");

    a_prefetch_quiet: assert property (req_valid_i && req_i.kind == slpc_pkg::KIND_ACCESS
        && req_i.atype == slpc_pkg::ACC_PREFETCH |=> resp_valid_o && !resp_o.fault)
        else $error("prefetch raised a fault");

    a_fault_no_update: assert property (s_fault_resp |->
        !acc_wr_o && $stable(current_priv_level_o))
        else $error("faulted request updated state");

    a_null_load_ok: assert property (s_load_data ##0 sel_null |=> !resp_o.fault)
        else $error("null selector load faulted");

    a_empty_desc: assert property (req_valid_i && check_en
        && req_i.kind == slpc_pkg::KIND_LOAD && req_i.acc == 8'h00
        && !(sel_null && (req_i.seg == slpc_pkg::SEG_DS || req_i.seg == slpc_pkg::SEG_ES))
        |=> resp_o.fault && resp_o.err == $past(sel_err))
        else $error("empty descriptor load not refused");

    a_wb_ack_pulse: assert property (ack_o |=> !ack_o)
        else $error("ack held for two cycles");

endmodule

/* File: testbench/slpc_exec_model.sv */
// Execution-side model: issues checker requests, keeps accessed bits
`timescale 1ns/1ps
module slpc_exec_model (
    input  wire logic           clk_i,
    output logic                req_valid_o,
    output slpc_pkg::slpc_req_t req_o,
    input  wire logic           acc_wr_i,
    input  wire logic [15:0]    acc_sel_i,
    input  wire logic [7:0]     acc_byte_i
);
    // Small table, low index bits only
    logic [7:0] desc_acc [0:31];
    initial begin
        req_valid_o = 1'b0;
        req_o = '0;
    end
    // Accessed-bit write-back from the checker
    always @(posedge clk_i) begin
        if (acc_wr_i === 1'b1) begin
            desc_acc[acc_sel_i[6:2]] <= acc_byte_i;
        end
    end
    // One request per edge; calls may follow back to back
    task automatic send(input slpc_pkg::slpc_req_t r);
        @(posedge clk_i);
        req_valid_o <= 1'b1;
        req_o <= r;
    endtask
    // Idle request bus shows no stale value
    task automatic idle();
        @(posedge clk_i);
        req_valid_o <= 1'b0;
        req_o <= ~req_o;
    endtask
endmodule

/* File: testbench/tb.sv */
// Self-checking bench for the segment load protection checker
`timescale 1ns/1ps
module tb;
    localparam slpc_pkg::slpc_kind_t K_LD = slpc_pkg::KIND_LOAD, K_XF = slpc_pkg::KIND_XFER,
        K_RT = slpc_pkg::KIND_RET, K_AC = slpc_pkg::KIND_ACCESS;
    localparam slpc_pkg::slpc_seg_t S_ES = slpc_pkg::SEG_ES, S_CS = slpc_pkg::SEG_CS,
        S_SS = slpc_pkg::SEG_SS, S_DS = slpc_pkg::SEG_DS;
    localparam slpc_pkg::slpc_atype_t A_RD = slpc_pkg::ACC_READ, A_WR = slpc_pkg::ACC_WRITE,
        A_FE = slpc_pkg::ACC_FETCH, A_PF = slpc_pkg::ACC_PREFETCH;
    logic                 clk_i = 1'b0;
    logic                 rst_i = 1'b1;
    logic [7:0]           adr = 8'h00;
    logic [31:0]          wdat = 32'h0;
    logic [31:0]          rdat;
    logic                 we = 1'b0;
    logic [3:0]           sel = 4'h0;
    logic                 cyc = 1'b0;
    logic                 stb = 1'b0;
    logic                 ack;
    logic                 req_valid;
    slpc_pkg::slpc_req_t  req;
    logic                 resp_valid;
    slpc_pkg::slpc_resp_t resp;
    logic                 acc_wr;
    logic [15:0]          acc_sel;
    logic [7:0]           acc_byte;
    logic [1:0]           level;
    logic [39:0]          q [$];
    logic [39:0]          e;
    logic [31:0]          d;
    logic [15:0]          lm;
    logic [15:0]          of;
    int                   err_total = 0;
    int                   comparisons = 0;

    always #25 clk_i = ~clk_i;

    slpc_checker i_slpc_checker (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr), .dat_i(wdat),
        .dat_o(rdat), .we_i(we), .sel_i(sel), .cyc_i(cyc), .stb_i(stb), .ack_o(ack),
        .req_valid_i(req_valid), .req_i(req), .resp_valid_o(resp_valid), .resp_o(resp),
        .acc_wr_o(acc_wr), .acc_sel_o(acc_sel), .acc_byte_o(acc_byte),
        .current_priv_level_o(level));
    slpc_exec_model i_slpc_exec_model (.clk_i(clk_i), .req_valid_o(req_valid), .req_o(req),
        .acc_wr_i(acc_wr), .acc_sel_i(acc_sel), .acc_byte_i(acc_byte));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic final_report();
        $display("comparisons %0d err_total %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Classic Wishbone cycle, held until ack is sampled high
    task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] dv);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        adr <= a;
        we <= w;
        wdat <= dv;
        sel <= 4'hf;
        // No local limit: a hung slave is caught by the watchdog
        do begin
            @(posedge clk_i);
        end while (ack !== 1'b1);
        d = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    // Expectation noted from kind and fault; selector faults name the selector
    task automatic r(input slpc_pkg::slpc_kind_t k, input slpc_pkg::slpc_seg_t s,
                     input logic [15:0] sl, input logic [7:0] ac, input logic [15:0] lim,
                     input logic [15:0] ofs, input slpc_pkg::slpc_atype_t at, input logic f);
        logic ld;
        ld = (k != K_AC);
        q.push_back({!f && ld && (sl[15:2] != 14'h0), f,
                     (f && ld) ? {sl[15:2], 2'h0} : 16'h0, sl[15:2], ac | 8'h01});
        i_slpc_exec_model.send('{k, s, sl, ac, lim, ofs, at});
    endtask

    task automatic lvl(input logic [1:0] x);
        i_slpc_exec_model.idle();
        @(negedge clk_i);
        check({30'h0, level}, {30'h0, x});
    endtask

    // Oldest note compared whenever a response appears
    always @(negedge clk_i) begin
        if (resp_valid === 1'b1) begin
            e = (q.size() > 0) ? q.pop_front() : 40'hff_ffff_ffff;
            check({14'h0, acc_wr, resp}, {14'h0, e[39:22]});
            if (e[39]) begin
                check({acc_sel[15:2], acc_byte}, e[21:0]);
            end
        end
    end

    // Watchdog, far beyond the less than a hundred cycles the run needs
    initial begin
        #(4000 * 50);
        err_total++;
        final_report();
    end

    initial begin
        d = $urandom(32'ha531);
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(slpc_pkg::ADR_CTRL, 1'b0, 32'h0);
        check(d, slpc_pkg::CTRL_RST);
        wb(8'h40, 1'b1, 32'hffff_ffff);
        wb(8'h40, 1'b0, 32'h0);
        check(d, 32'h0);
        // Loads and accesses at level zero, back to back
        r(K_LD, S_DS, 16'h0008, 8'h93, 16'h1000, 16'h0, A_RD, 1'b0);
        r(K_LD, S_DS, 16'h0010, 8'h00, 16'h1000, 16'h0, A_RD, 1'b1);
        r(K_LD, S_SS, 16'h0018, 8'h9b, 16'h1000, 16'h0, A_RD, 1'b1);
        r(K_LD, S_DS, 16'h0020, 8'h99, 16'h1000, 16'h0, A_RD, 1'b1);
        r(K_LD, S_DS, 16'h002b, 8'hf3, 16'h1000, 16'h0, A_RD, 1'b0);
        r(K_LD, S_DS, 16'h0033, 8'hb3, 16'h1000, 16'h0, A_RD, 1'b1);
        r(K_LD, S_SS, 16'h0038, 8'h93, 16'h1000, 16'h0, A_RD, 1'b0);
        r(K_LD, S_SS, 16'h0040, 8'hb3, 16'h1000, 16'h0, A_RD, 1'b1);
        r(K_LD, S_ES, 16'h0048, 8'h97, 16'h1000, 16'h0, A_RD, 1'b0);
        r(K_AC, S_ES, 16'h0048, 8'h97, 16'h1000, 16'h1000, A_RD, 1'b1);
        r(K_AC, S_ES, 16'h0048, 8'h97, 16'h1000, 16'h1001, A_RD, 1'b0);
        r(K_LD, S_DS, 16'h0050, 8'h9b, 16'h1000, 16'h0, A_RD, 1'b0);
        r(K_AC, S_DS, 16'h0050, 8'h9b, 16'h1000, 16'h1000, A_RD, 1'b0);
        r(K_AC, S_DS, 16'h0050, 8'h9b, 16'h1000, 16'h1001, A_RD, 1'b1);
        r(K_AC, S_DS, 16'h0050, 8'h9b, 16'h1000, 16'h0010, A_WR, 1'b1);
        // Random offsets against a random limit
        lm = $urandom;
        r(K_LD, S_DS, 16'h0008, 8'h93, lm, 16'h0, A_RD, 1'b0);
        repeat (16) begin
            of = $urandom;
            r(K_AC, S_DS, 16'h0008, 8'h93, lm, of, A_RD, of > lm);
        end
        r(K_LD, S_DS, 16'h0000, 8'h00, 16'h0, 16'h0, A_RD, 1'b0);
        r(K_AC, S_DS, 16'h0000, 8'h00, 16'h0, 16'h0, A_RD, 1'b1);
        r(K_XF, S_CS, 16'h0058, 8'h99, 16'h0100, 16'h0, A_FE, 1'b0);
        r(K_AC, S_CS, 16'h0058, 8'h99, 16'h0100, 16'h0010, A_RD, 1'b1);
        r(K_AC, S_CS, 16'h0058, 8'h99, 16'h0100, 16'h0200, A_PF, 1'b0);
        r(K_AC, S_CS, 16'h0058, 8'h99, 16'h0100, 16'h0200, A_FE, 1'b1);
        r(K_AC, S_CS, 16'h0058, 8'h99, 16'h0100, 16'h0100, A_FE, 1'b0);
        r(K_XF, S_CS, 16'h0060, 8'hb9, 16'h0100, 16'h0, A_FE, 1'b1);
        lvl(2'h0);
        check({24'h0, i_slpc_exec_model.desc_acc[2]}, 32'h93);
        // Return outward, then checks at level three
        r(K_RT, S_CS, 16'h006b, 8'hfb, 16'hffff, 16'h0, A_FE, 1'b0);
        r(K_LD, S_DS, 16'h0008, 8'h93, 16'hffff, 16'h0, A_RD, 1'b1);
        r(K_XF, S_CS, 16'h0070, 8'h9f, 16'hffff, 16'h0, A_FE, 1'b0);
        r(K_RT, S_CS, 16'h0008, 8'h9b, 16'hffff, 16'h0, A_FE, 1'b1);
        lvl(2'h3);
        wb(slpc_pkg::ADR_STATUS, 1'b0, 32'h0);
        check({29'h0, d[2:0]}, 32'h7);
        wb(slpc_pkg::ADR_ERR, 1'b0, 32'h0);
        check(d, 32'h0000_0008);
        wb(slpc_pkg::ADR_SEL_CS, 1'b0, 32'h0);
        check(d, 32'h0038_0073);
        wb(slpc_pkg::ADR_SEL_DE, 1'b0, 32'h0);
        check(d, 32'h0000_0048);
        // Checks off: a bad load commits without fault
        wb(slpc_pkg::ADR_CTRL, 1'b1, 32'h0);
        r(K_LD, S_SS, 16'h0018, 8'h9b, 16'hffff, 16'h0, A_RD, 1'b0);
        i_slpc_exec_model.idle();
        wb(slpc_pkg::ADR_CTRL, 1'b1, 32'h1);
        repeat (3) @(posedge clk_i);
        check(q.size(), 32'h0);
        final_report();
    end
endmodule
